//--- hdl/adc_global_conversion_control.sv
// Global request and busy registers for four converter units
// ----------------------------------------------------------------
// Summary of operation
// - Writing one to request bit 0 starts a conversion of all eight channels of unit 1.
// - Request bits 1, 2 and 3 do the same for units 2, 3 and 4.
// - A request bit clears itself without software writing zero.
// - A request for a unit in sequencer mode is dropped and leaves busy untouched.
// - A unit's busy flag is high while sampling or result transfer is under way.
// - In manual mode a request write sets the unit's busy flag.
// - Busy flags of units 2 to 4 sit at status bits 1 to 3 and act like unit 1.
// - The status register at 0x004 is read-only, busy resets to zero, bits 31:4 reserved.
// - The request register at 0x000 resets to zero with bits 31:4 reserved.
// - Request bits are set by writing one only; zero writes do nothing.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module adc_global_conversion_control
  import adc_gc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire reg_req_t reg_req_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Unit mode and sequencer
  input wire logic [NUM_UNITS-1:0] seq_mode_i,
  input wire logic [NUM_UNITS-1:0] seq_start_i,
  // Converter chips and data store
  input wire logic [NUM_UNITS-1:0] chip_busy_i,
  input wire logic [NUM_UNITS-1:0] xfer_done_i,
  output logic [NUM_UNITS-1:0] convst_o,
  output logic [NUM_UNITS-1:0] xfer_req_o
);

  // ----------------------------------------------------------------
  // Request register
  // ----------------------------------------------------------------
  logic [NUM_UNITS-1:0] request_ff;
  logic [NUM_UNITS-1:0] nxt_request;
  logic req_hit;

  assign req_hit = reg_req_i.wr && reg_req_i.be[0] && (reg_req_i.addr == REQUEST_OFS);

  // Bits live one cycle; only ones in the write set them
  always_comb
  begin
    nxt_request = '0;
    if (req_hit)
    begin
      nxt_request = reg_req_i.wdata[NUM_UNITS-1:0] & ~seq_mode_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      request_ff <= REQUEST_RST;
    end
    else
    begin
      request_ff <= nxt_request;
    end
  end

  // ----------------------------------------------------------------
  // Converter units
  // ----------------------------------------------------------------
  logic [NUM_UNITS-1:0] unit_busy;
  logic [NUM_UNITS-1:0] unit_start;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++)
    begin : g_unit
      // A request while busy is lost, the unit keeps its running job
      assign unit_start[gi] = request_ff[gi] | (seq_mode_i[gi] & seq_start_i[gi]);
      unit_conv_ctrl u_ctrl (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(unit_start[gi]),
        .xfer_done_i(xfer_done_i[gi]),
        .busy_o(unit_busy[gi]),
        .chip_busy_i(chip_busy_i[gi]),
        .convst_o(convst_o[gi]),
        .xfer_req_o(xfer_req_o[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status and read path
  // ----------------------------------------------------------------
  logic [NUM_UNITS-1:0] busy_ff;
  logic [NUM_UNITS-1:0] nxt_busy;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  always_comb
  begin
    nxt_busy = unit_busy;
    nxt_rvalid = reg_req_i.rd;
    nxt_rdata = '0;
    if (reg_req_i.rd)
    begin
      if (reg_req_i.addr == STATUS_OFS)
      begin
        nxt_rdata = {{(DATA_W-NUM_UNITS){1'b0}}, busy_ff};
      end
      else if (reg_req_i.addr == REQUEST_OFS)
      begin
        nxt_rdata = {{(DATA_W-NUM_UNITS){1'b0}}, request_ff};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      busy_ff <= BUSY_RST;
      rdata_ff <= RDATA_RST;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= nxt_busy;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_req_self_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    (request_ff != '0 && !req_hit) |=> request_ff == '0)
    else $error("request bit did not clear itself");

  a_seq_req_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
    req_hit |=> (request_ff & $past(seq_mode_i)) == '0)
    else $error("request taken in sequencer mode");

  a_zero_write_noeffect: assert property (@(posedge clk_i) disable iff (srst_i)
    (req_hit && reg_req_i.wdata[NUM_UNITS-1:0] == '0) |=> request_ff == '0)
    else $error("zero write set a request bit");

  a_manual_sets_busy: assert property (@(posedge clk_i) disable iff (srst_i)
    (req_hit && reg_req_i.wdata[0] && !seq_mode_i[0] && !unit_busy[0]
      && !(seq_mode_i[0] && seq_start_i[0])) |-> ##3 busy_ff[0])
    else $error("manual request did not set busy");

  a_status_readonly: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_req_i.wr && reg_req_i.addr == STATUS_OFS && unit_busy == '0 && request_ff == '0
      && seq_start_i == '0) |-> ##2 busy_ff == '0)
    else $error("status write changed busy");

  a_read_reserved_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    reg_req_i.rd |=> reg_rvalid_o && reg_rdata_o[DATA_W-1:NUM_UNITS] == '0)
    else $error("read answer late or reserved bits set");

  a_status_tracks_busy: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_req_i.rd && reg_req_i.addr == STATUS_OFS)
      |=> reg_rdata_o[NUM_UNITS-1:0] == $past(busy_ff))
    else $error("status read differs from busy flags");

  // ----------------------------------------------------------------
  // Per-unit checks
  // ----------------------------------------------------------------
  // Status lags the unit by one cycle, hence the two- and three-cycle delays
  a_write_sets_request: assert property (@(posedge clk_i) disable iff (srst_i)
    (req_hit && reg_req_i.wdata[0] && !seq_mode_i[0]) |=> request_ff[0])
    else $error("request bit 0 not set by write");

  a_unit2_request: assert property (@(posedge clk_i) disable iff (srst_i)
    (req_hit && reg_req_i.wdata[1] && !seq_mode_i[1]) |=> request_ff[1])
    else $error("request bit 1 not set by write");

  a_unit4_sets_busy: assert property (@(posedge clk_i) disable iff (srst_i)
    (req_hit && reg_req_i.wdata[3] && !seq_mode_i[3] && !unit_busy[3])
      |-> ##3 busy_ff[3])
    else $error("request bit 3 did not start unit 4");

  a_seq_busy_untouched: assert property (@(posedge clk_i) disable iff (srst_i)
    (req_hit && reg_req_i.wdata[1] && seq_mode_i[1] && !unit_busy[1] && !request_ff[1]
      && !seq_start_i[1]) |-> ##2 !busy_ff[1])
    else $error("sequencer unit went busy on a request write");

  a_status_shows_unit3: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(unit_busy[2]) |=> busy_ff[2])
    else $error("unit 3 busy not shown in status");

  a_seq_start_honoured: assert property (@(posedge clk_i) disable iff (srst_i)
    (seq_mode_i[2] && seq_start_i[2] && !unit_busy[2]) |-> ##2 busy_ff[2])
    else $error("sequencer start did not set busy");

  a_busy_after_results: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(busy_ff[0]) |-> $past(xfer_done_i[0], 2))
    else $error("status busy dropped before results stored");

  // ----------------------------------------------------------------
  // Register map checks
  // ----------------------------------------------------------------
  a_idle_read_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    !reg_req_i.rd |=> !reg_rvalid_o && reg_rdata_o == '0)
    else $error("read answer without a read");

  a_request_readback: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_req_i.rd && reg_req_i.addr == REQUEST_OFS)
      |=> reg_rdata_o[NUM_UNITS-1:0] == $past(request_ff))
    else $error("request read differs from request bits");

  // No disable here: this one watches the reset itself
  a_flags_after_reset: assert property (@(posedge clk_i)
    srst_i |=> busy_ff == BUSY_RST && request_ff == REQUEST_RST)
    else $error("flags not cleared by reset");

endmodule // adc_global_conversion_control

//--- hdl/adc_gc_pkg.sv
// Shared constants and types for the global converter control block
package adc_gc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_UNITS = 4;
  localparam logic [ADDR_W-1:0] REQUEST_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [NUM_UNITS-1:0] REQUEST_RST = 4'h0;
  localparam logic [NUM_UNITS-1:0] BUSY_RST = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONVST_MIN_NS = 40;
  localparam int CONVST_CYC_INT = (CONVST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] CONVST_CYC = 3'(CONVST_CYC_INT);
  localparam logic [2:0] CNT_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] be;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_PULSE = 3'h1,
    S_RISE = 3'h3,
    S_FALL = 3'h2,
    S_XFER = 3'h6
  } unit_state_t;

endpackage

//--- hdl/unit_conv_ctrl.sv
// Conversion sequencing for one eight-channel converter unit
`timescale 1ns/1ps
module unit_conv_ctrl
  import adc_gc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control side
  input wire logic start_i,
  input wire logic xfer_done_i,
  output logic busy_o,
  // Converter chip
  input wire logic chip_busy_i,
  output logic convst_o,
  output logic xfer_req_o
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic sync1_ff;
  logic sync2_ff;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= chip_busy_i;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  unit_state_t state_ff;
  unit_state_t nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic convst_ff;
  logic nxt_convst;
  logic xfer_ff;
  logic nxt_xfer;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_convst = convst_ff;
    nxt_xfer = xfer_ff;
    unique case (state_ff)
      S_IDLE:
      begin
        if (start_i)
        begin
          nxt_state = S_PULSE;
          nxt_convst = 1'b1;
          nxt_cnt = CONVST_CYC - 3'h1;
        end
      end
      S_PULSE:
      begin
        if (cnt_ff == CNT_RST)
        begin
          nxt_state = S_RISE;
          nxt_convst = 1'b0;
        end
        else
        begin
          nxt_cnt = cnt_ff - 3'h1;
        end
      end
      // Chip busy shorter than one clock would be missed here
      S_RISE:
      begin
        if (sync2_ff)
        begin
          nxt_state = S_FALL;
        end
      end
      S_FALL:
      begin
        if (!sync2_ff)
        begin
          nxt_state = S_XFER;
          nxt_xfer = 1'b1;
        end
      end
      S_XFER:
      begin
        if (xfer_done_i)
        begin
          nxt_state = S_IDLE;
          nxt_xfer = 1'b0;
        end
      end
      default:
      begin
        nxt_state = S_IDLE;
        nxt_convst = 1'b0;
        nxt_xfer = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= S_IDLE;
      cnt_ff <= CNT_RST;
      convst_ff <= 1'b0;
      xfer_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      convst_ff <= nxt_convst;
      xfer_ff <= nxt_xfer;
    end
  end

  // Busy spans pulse, sampling and readout
  assign busy_o = (state_ff != S_IDLE);
  assign convst_o = convst_ff;
  assign xfer_req_o = xfer_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_start_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_ff == S_IDLE && start_i) |=> convst_ff [*4] ##1 !convst_ff)
    else $error("conversion start pulse wrong");

  a_busy_until_stored: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(busy_o) |-> $past(xfer_done_i) && $past(xfer_ff))
    else $error("busy dropped before results stored");

  a_busy_covers_work: assert property (@(posedge clk_i) disable iff (srst_i)
    (convst_ff || xfer_ff || sync2_ff) |-> busy_o)
    else $error("busy low during sampling or transfer");

endmodule // unit_conv_ctrl

//--- tb/conv_chip_model.sv
// Behavioural converter chips and result store for four units
`timescale 1ns/1ps
module conv_chip_model
  import adc_gc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pace select
  input wire logic slow_i,
  // From the block
  input wire logic [NUM_UNITS-1:0] convst_i,
  input wire logic [NUM_UNITS-1:0] xfer_req_i,
  // To the block
  output logic [NUM_UNITS-1:0] chip_busy_o,
  output logic [NUM_UNITS-1:0] xfer_done_o
);
  logic [NUM_UNITS-1:0] convst_d;
  int busy_cnt [NUM_UNITS];
  int xfer_cnt [NUM_UNITS];

  initial
  begin
    chip_busy_o = '0;
    xfer_done_o = '0;
    convst_d = '0;
  end

  // ----------------------------------------------------------------
  // Sampling after the start pulse ends, then one done per readout
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    convst_d <= convst_i;
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      xfer_done_o[u] <= 1'b0;
      if (srst_i)
      begin
        busy_cnt[u] <= 0;
        xfer_cnt[u] <= 0;
        chip_busy_o[u] <= 1'b0;
      end
      else
      begin
        if (convst_d[u] && !convst_i[u])
        begin
          busy_cnt[u] <= slow_i ? 30 : 8;
          chip_busy_o[u] <= 1'b1;
        end
        else if (busy_cnt[u] > 1)
          busy_cnt[u] <= busy_cnt[u] - 1;
        else
        begin
          busy_cnt[u] <= 0;
          chip_busy_o[u] <= 1'b0;
        end
        // Done comes once; held off until the request is withdrawn
        if (!xfer_req_i[u])
          xfer_cnt[u] <= 0;
        else if (xfer_cnt[u] >= 0 && xfer_cnt[u] == (slow_i ? 20 : 3))
        begin
          xfer_done_o[u] <= 1'b1;
          xfer_cnt[u] <= -1;
        end
        else if (xfer_cnt[u] >= 0)
          xfer_cnt[u] <= xfer_cnt[u] + 1;
      end
    end
  end
endmodule // conv_chip_model

//--- tb/testbench.sv
// Self-checking bench for the global converter control block
`timescale 1ns/1ps
module testbench
  import adc_gc_pkg::*;
;
  typedef struct packed {
    logic [3:0] wdata;
    logic [3:0] mode;
    logic [3:0] sstart;
    logic [3:0] exp;
  } row_t;
  localparam row_t ROWS [9] = '{
    '{4'h1, 4'h0, 4'h0, 4'h1}, '{4'h2, 4'h0, 4'h0, 4'h2},
    '{4'h4, 4'h0, 4'h0, 4'h4}, '{4'h8, 4'h0, 4'h0, 4'h8},
    '{4'h2, 4'h2, 4'h0, 4'h0}, '{4'h0, 4'h0, 4'h0, 4'h0},
    '{4'h0, 4'h4, 4'h4, 4'h4}, '{4'hf, 4'h0, 4'h0, 4'hf},
    '{4'h0, 4'h0, 4'h1, 4'h0}};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic slow = 1'b0;
  logic [NUM_UNITS-1:0] seq_mode = '0;
  logic [NUM_UNITS-1:0] seq_start = '0;
  logic [NUM_UNITS-1:0] chip_busy, xfer_done, convst, xfer_req;
  logic [NUM_UNITS-1:0] conv_seen = '0;
  logic [NUM_UNITS-1:0] done_seen = '0;
  logic [31:0] d;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  adc_global_conversion_control dut (.clk_i(clk_i), .srst_i(srst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .seq_mode_i(seq_mode),
    .seq_start_i(seq_start), .chip_busy_i(chip_busy), .xfer_done_i(xfer_done),
    .convst_o(convst), .xfer_req_o(xfer_req));
  conv_chip_model chips (.clk_i(clk_i), .srst_i(srst_i), .slow_i(slow), .convst_i(convst),
    .xfer_req_i(xfer_req), .chip_busy_o(chip_busy), .xfer_done_o(xfer_done));

  always #5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Pulse catchers and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    conv_seen <= conv_seen | convst;
    done_seen <= done_seen | xfer_done;
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("Error at %0t: timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    req.rd = 1'b1;
    req.addr = a;
    tick();
    check(32'(rvalid), 32'h1);
    v = rdata;
    req.rd = 1'b0;
    tick();
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    req.wr = 1'b1;
    req.be = 4'hf;
    req.addr = a;
    req.wdata = v;
    tick();
    req.wr = 1'b0;
  endtask

  // Polls status; software never reads results before this
  task automatic wait_idle(input logic [3:0] exp);
    logic [31:0] v;
    v = 32'hffff_ffff;
    for (int n = 0; n < 300 && v !== 32'h0; n++)
      reg_read(STATUS_OFS, v);
    check(v, 32'h0);
    check(32'(xfer_req), 32'h0);
    check(32'(done_seen), 32'(exp));
    check(32'(conv_seen), 32'(exp));
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    reg_read(REQUEST_OFS, d);
    check(d, 32'h0);
    reg_read(STATUS_OFS, d);
    check(d, 32'h0);
    reg_read(12'h008, d);
    check(d, 32'h0);
    $display("Test reset values done");
    // Every row starts from idle units
    for (int i = 0; i < 9; i++)
    begin
      slow = i[0];
      seq_mode = ROWS[i].mode;
      conv_seen = '0;
      done_seen = '0;
      seq_start = ROWS[i].sstart;
      reg_write(REQUEST_OFS, 32'(ROWS[i].wdata));
      seq_start = '0;
      repeat (3) tick();
      reg_read(STATUS_OFS, d);
      check(d, 32'(ROWS[i].exp));
      wait_idle(ROWS[i].exp);
      $display("Test row %0d done", i);
    end
    seq_mode = '0;
    conv_seen = '0;
    done_seen = '0;
    // Back-to-back writes; a leftover bit would restart unit 1
    req.wr = 1'b1;
    req.be = 4'hf;
    req.addr = REQUEST_OFS;
    req.wdata = 32'h1;
    tick();
    req.wdata = 32'h2;
    tick();
    req.wr = 1'b0;
    repeat (2) tick();
    reg_read(REQUEST_OFS, d);
    check(d, 32'h0);
    wait_idle(4'h3);
    $display("Test back-to-back done");
    conv_seen = '0;
    done_seen = '0;
    reg_write(STATUS_OFS, 32'hf);
    repeat (3) tick();
    reg_read(STATUS_OFS, d);
    check(d, 32'h0);
    check(32'(conv_seen), 32'h0);
    $display("Test status write done");
    reg_write(REQUEST_OFS, 32'h1);
    repeat (3) tick();
    srst_i = 1'b1;
    repeat (12) tick();
    srst_i = 1'b0;
    check(32'(convst), 32'h0);
    check(32'(xfer_req), 32'h0);
    reg_read(STATUS_OFS, d);
    check(d, 32'h0);
    $display("Test mid-run reset done");
    print_verdict();
  end
endmodule // testbench
